// file: hw/eif_pkg.sv
// Constants shared by the Ethernet interrupt flag logic
package eif_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Processor-side register indices
  localparam logic [2:0] IDX_IRQ_ENABLE = 3'h0;
  localparam logic [2:0] IDX_IRQ_FLAGS = 3'h1;
  localparam logic [2:0] IDX_STATUS = 3'h2;
  localparam logic [2:0] IDX_CONTROL_TWO = 3'h3;
  localparam logic [2:0] IDX_PKT_COUNT = 3'h4;

  // Enable and flag bit positions
  localparam int BIT_PKT = 6;
  localparam int BIT_DMA = 5;
  localparam int BIT_LINK = 4;
  localparam int BIT_TX = 3;
  localparam int BIT_TXERR = 1;
  localparam int BIT_RXERR = 0;
  localparam logic [7:0] IRQ_ENABLE_MASK = 8'h7b;
  localparam logic [7:0] IRQ_FLAGS_CLR_MASK = 8'h2b;
  localparam logic [7:0] RESET_BYTE = 8'h00;

  // Status and control bits
  localparam int BIT_BUFFER_ERROR = 6;
  localparam int BIT_TX_ABORT = 1;
  localparam int BIT_PKT_DECREMENT = 6;
  localparam logic [7:0] STATUS_CLR_MASK = 8'h42;

  ////////////////////////////////////////////////////////////////////////////
  // Management-side PHY registers
  localparam logic [4:0] MII_IRQ_ENABLE = 5'h12;
  localparam logic [4:0] MII_IRQ_FLAGS = 5'h13;
  localparam int PHY_BIT_LINK_EN = 4;
  localparam int PHY_BIT_GLOBAL_EN = 1;
  localparam int PHY_BIT_LINK_FLAG = 4;
  localparam int PHY_BIT_GLOBAL_FLAG = 2;
  localparam logic [15:0] PHY_ENABLE_MASK = 16'h0012;
  localparam logic [15:0] RESET_WORD = 16'h0000;

  ////////////////////////////////////////////////////////////////////////////
  // Transmit and receive figures
  localparam logic [4:0] TX_MAX_COLLISIONS = 5'h0f;
  localparam logic [10:0] TX_LATE_BYTES = 11'h040;
  localparam logic [15:0] TX_STATUS_OFFSET = 16'h0001;
  localparam logic [7:0] PKT_COUNT_MAX = 8'hff;

  // Bits that a write of zero clears; writing one leaves them alone
  function automatic logic [7:0] eif_clear_hits(input logic [7:0] wd, input logic [7:0] mask);
    return ~wd & mask;
  endfunction : eif_clear_hits

endpackage : eif_pkg

// file: hw/eif_evt_if.sv
// Event carrier between the flag core and its PHY and abort helpers
`timescale 1ns/10ps
interface eif_evt_if;
  logic linkFlag;
  logic linkQualEn;
  logic txAbort;
  logic txUnderrun;
  modport phy (output linkFlag, output linkQualEn);
  modport txab (output txAbort, output txUnderrun);
  modport core (input linkFlag, input linkQualEn, input txAbort, input txUnderrun);
endinterface : eif_evt_if

// file: hw/eif_phy_irq.sv
// PHY-side interrupt enable and read-to-clear flag registers
`timescale 1ns/10ps
module eif_phy_irq (
  input wire logic mclk,
  input wire logic rst_n,
  eif_evt_if.phy evt,
  input wire logic [4:0] miiAddr,
  input wire logic miiWr,
  input wire logic [15:0] miiWrData,
  input wire logic miiRd,
  output logic [15:0] miiRdData,
  input wire logic phyLinkEvent
);
  import eif_pkg::*;

  logic [15:0] phyEnable_ff;
  logic phyLinkFlag_ff;
  logic phyGlobalFlag_ff;
  logic [15:0] miiRdData_ff;
  logic flagRead;

  assign flagRead = miiRd && (miiAddr == MII_IRQ_FLAGS);

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      phyEnable_ff <= RESET_WORD;
    end else if (miiWr && (miiAddr == MII_IRQ_ENABLE)) begin
      phyEnable_ff <= miiWrData & PHY_ENABLE_MASK; // [R16]
    end
  end

  // Event in the read cycle survives, so no change is lost
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      phyLinkFlag_ff <= 1'b0;
      phyGlobalFlag_ff <= 1'b0;
    end else begin
      if (phyLinkEvent) begin
        phyLinkFlag_ff <= 1'b1; // [R17]
      end else if (flagRead) begin
        phyLinkFlag_ff <= 1'b0; // [R20]
      end
      if (phyLinkEvent && phyEnable_ff[PHY_BIT_LINK_EN]) begin
        phyGlobalFlag_ff <= 1'b1; // [R17]
      end else if (flagRead) begin
        phyGlobalFlag_ff <= 1'b0; // [R20]
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      miiRdData_ff <= RESET_WORD;
    end else if (flagRead) begin
      miiRdData_ff <= RESET_WORD;
      miiRdData_ff[PHY_BIT_LINK_FLAG] <= phyLinkFlag_ff;
      miiRdData_ff[PHY_BIT_GLOBAL_FLAG] <= phyGlobalFlag_ff;
    end else if (miiRd && (miiAddr == MII_IRQ_ENABLE)) begin
      miiRdData_ff <= phyEnable_ff;
    end
  end

  assign miiRdData = miiRdData_ff;
  assign evt.linkQualEn = phyEnable_ff[PHY_BIT_LINK_EN] && phyEnable_ff[PHY_BIT_GLOBAL_EN];
  assign evt.linkFlag = phyGlobalFlag_ff && evt.linkQualEn; // [R18]

  ////////////////////////////////////////////////////////////////////////////
  property p_read_clears;
    @(posedge mclk) disable iff (!rst_n)
      flagRead && !phyLinkEvent |=> !phyLinkFlag_ff && !phyGlobalFlag_ff && !evt.linkFlag;
  endproperty
  a_read_clears: assert property (p_read_clears) else $error("flag read did not clear"); // [R20]

  property p_link_gated;
    @(posedge mclk) disable iff (!rst_n)
      evt.linkFlag |-> phyEnable_ff[PHY_BIT_LINK_EN] && phyEnable_ff[PHY_BIT_GLOBAL_EN];
  endproperty
  a_link_gated: assert property (p_link_gated) else $error("link flag without enables"); // [R18]

endmodule : eif_phy_irq

// file: hw/eif_tx_abort.sv
// Transmit abort detection from collision, deferral, size and underrun events
`timescale 1ns/10ps
module eif_tx_abort #(
  parameter logic [4:0] MAX_COLLISIONS = eif_pkg::TX_MAX_COLLISIONS,
  parameter logic [10:0] LATE_BYTES = eif_pkg::TX_LATE_BYTES
) (
  input wire logic mclk,
  input wire logic rst_n,
  eif_evt_if.txab evt,
  input wire logic txStart,
  input wire logic txCollision,
  input wire logic [10:0] txByteCount,
  input wire logic txDeferLimit,
  input wire logic deferEn,
  input wire logic [15:0] txFrameLength,
  input wire logic [15:0] maxFrameLength,
  input wire logic hugeFrameEn,
  input wire logic perPacketOverride,
  input wire logic perPacketHugeEn,
  input wire logic txUnderrunEvt,
  input wire logic fullDuplex
);
  import eif_pkg::*;

  logic [4:0] collCount_ff;
  logic abort_ff;
  logic underrun_ff;
  logic hugeAllowed;
  logic oversize;
  logic halfCause;
  logic cause;

  always_ff @(posedge mclk) begin
    if (!rst_n || txStart) begin
      collCount_ff <= 5'h00;
    end else if (txCollision && (collCount_ff != MAX_COLLISIONS)) begin
      collCount_ff <= collCount_ff + 5'h01;
    end
  end

  assign hugeAllowed = perPacketOverride ? perPacketHugeEn : hugeFrameEn;
  assign oversize = txStart && (txFrameLength > maxFrameLength) && !hugeAllowed; // [R10]
  // Shared-medium causes cannot happen on a full-duplex link
  assign halfCause = !fullDuplex && ((txCollision && (collCount_ff == MAX_COLLISIONS))
    || (txCollision && (txByteCount > LATE_BYTES)) || (txDeferLimit && !deferEn)); // [R10] [R14]
  assign cause = halfCause || oversize || txUnderrunEvt; // [R10]

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      abort_ff <= 1'b0;
      underrun_ff <= 1'b0;
    end else begin
      abort_ff <= cause;
      underrun_ff <= txUnderrunEvt; // [R14]
    end
  end

  assign evt.txAbort = abort_ff;
  assign evt.txUnderrun = underrun_ff;

  ////////////////////////////////////////////////////////////////////////////
  property p_full_duplex_causes;
    @(posedge mclk) disable iff (!rst_n)
      fullDuplex && !oversize && !txUnderrunEvt |=> !evt.txAbort;
  endproperty
  a_full_duplex_causes: assert property (p_full_duplex_causes) else $error("bad full duplex abort"); // [R14]

  property p_sixteenth_collision;
    @(posedge mclk) disable iff (!rst_n)
      !fullDuplex && txCollision && (collCount_ff == MAX_COLLISIONS) |=> evt.txAbort;
  endproperty
  a_sixteenth_collision: assert property (p_sixteenth_collision) else $error("no collision abort"); // [R10]

endmodule : eif_tx_abort

// file: hw/eif_ethernet_interrupt_flags.sv
// Ethernet interrupt flags, enables, packet count and abort status
`timescale 1ns/10ps
// What this block does
// R1: Eight-bit enable register, six enables at 6,5,4,3,1,0, others zero, reset zero.
// R2: Packet pending flag reads high while packet count is nonzero.
// R3: DMA flag sets on copy or checksum completion; software clears it.
// R4: Link flag read-only, shows PHY link change, cleared by PHY flag read.
// R5: Transmit flag sets on transmit request falling; held until clear or reset.
// R6: Receive error sets on overflow, count already 255, or bandwidth shortage.
// R7: Receive error discards packet; flag clears only by software or reset.
// R8: Interrupt needs flag, its enable and the global enable together.
// R9: Bandwidth shortage also sets buffer error status; other receive errors do not.
// R10: Abort on excess collisions, late collision, deferral, oversize, or underrun.
// R11: Abort sets transmit error flag and transmit flag in the same cycle.
// R12: Abort clears transmit request, sets abort status, writes status at end plus one.
// R13: Software clears buffer error and abort status after handling an abort.
// R14: Full duplex aborts only on oversize or underrun; underrun sets buffer error.
// R15: Software deems transmit good if flag set, no abort, not self-cancelled.
// R16: PHY enable register sixteen bits, link enable bit 4, global bit 1.
// R17: PHY link flag bit 4, global flag bit 2, cleared when read.
// R18: Module link flag mirrors PHY global flag only when both PHY enables set.
// R19: Link interrupt needs module enable, both PHY enables and global enable.
// R20: PHY flag read clears module, global and link flags together.
// R21: All flags but link set on their events whatever the enables.
// R22: Master interrupt request when an enabled flag and global enable are set.
// R23: Interrupt level stays while a qualified flag is set, falls after last clear.
module eif_ethernet_interrupt_flags (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [2:0] regAddr,
  input wire logic regWr,
  input wire logic [7:0] regWrData,
  output logic [7:0] regRdData,
  input wire logic ethGlobalEn,
  input wire logic dmaDone,
  input wire logic txRequest,
  input wire logic [15:0] txEndPointer,
  input wire logic rxPacketDone,
  input wire logic rxOverflow,
  input wire logic rxBandwidthErr,
  input wire logic [4:0] miiAddr,
  input wire logic miiWr,
  input wire logic [15:0] miiWrData,
  input wire logic miiRd,
  output logic [15:0] miiRdData,
  input wire logic phyLinkEvent,
  input wire logic txStart,
  input wire logic txCollision,
  input wire logic [10:0] txByteCount,
  input wire logic txDeferLimit,
  input wire logic deferEn,
  input wire logic [15:0] txFrameLength,
  input wire logic [15:0] maxFrameLength,
  input wire logic hugeFrameEn,
  input wire logic perPacketOverride,
  input wire logic perPacketHugeEn,
  input wire logic txUnderrunEvt,
  input wire logic fullDuplex,
  output logic ethIrq,
  output logic rxDiscard,
  output logic txRequestClr,
  output logic txStatusWrite,
  output logic [15:0] txStatusAddr,
  output logic bufferError,
  output logic txAbortStatus
);
  import eif_pkg::*;

  eif_evt_if evt ();

  logic [7:0] irqEnable_ff;
  logic dmaFlag_ff;
  logic txFlag_ff;
  logic txErrFlag_ff;
  logic rxErrFlag_ff;
  logic [7:0] pktCount_ff;
  logic bufErr_ff;
  logic txAbortStat_ff;
  logic txReqPrev_ff;
  logic rxDiscard_ff;
  logic txReqClr_ff;
  logic txStatWr_ff;
  logic [15:0] txStatAddr_ff;
  logic [7:0] regRdData_ff;
  logic [7:0] flagVec;
  logic [7:0] statusVec;
  logic [7:0] qualified;
  logic [7:0] flagClr;
  logic [7:0] statusClr;
  logic txFall;
  logic rxCountFull;
  logic rxErrEvt;
  logic pktInc;
  logic packet_decrement;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers
  eif_phy_irq u_phy_irq (
    .mclk(mclk),
    .rst_n(rst_n),
    .evt(evt.phy),
    .miiAddr(miiAddr),
    .miiWr(miiWr),
    .miiWrData(miiWrData),
    .miiRd(miiRd),
    .miiRdData(miiRdData),
    .phyLinkEvent(phyLinkEvent)
  );

  eif_tx_abort u_tx_abort (
    .mclk(mclk),
    .rst_n(rst_n),
    .evt(evt.txab),
    .txStart(txStart),
    .txCollision(txCollision),
    .txByteCount(txByteCount),
    .txDeferLimit(txDeferLimit),
    .deferEn(deferEn),
    .txFrameLength(txFrameLength),
    .maxFrameLength(maxFrameLength),
    .hugeFrameEn(hugeFrameEn),
    .perPacketOverride(perPacketOverride),
    .perPacketHugeEn(perPacketHugeEn),
    .txUnderrunEvt(txUnderrunEvt),
    .fullDuplex(fullDuplex)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Register writes
  assign flagClr = (regWr && (regAddr == IDX_IRQ_FLAGS)) ?
    eif_clear_hits(regWrData, IRQ_FLAGS_CLR_MASK) : RESET_BYTE; // [R4]
  assign statusClr = (regWr && (regAddr == IDX_STATUS)) ?
    eif_clear_hits(regWrData, STATUS_CLR_MASK) : RESET_BYTE; // [R13]
  assign packet_decrement = regWr && (regAddr == IDX_CONTROL_TWO) && regWrData[BIT_PKT_DECREMENT]
    && (pktCount_ff != RESET_BYTE);

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      irqEnable_ff <= RESET_BYTE;
    end else if (regWr && (regAddr == IDX_IRQ_ENABLE)) begin
      irqEnable_ff <= regWrData & IRQ_ENABLE_MASK; // [R1]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Event flags; a set in the clear cycle wins
  assign txFall = txReqPrev_ff && !txRequest;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      txReqPrev_ff <= 1'b0;
    end else begin
      txReqPrev_ff <= txRequest;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      dmaFlag_ff <= 1'b0;
    end else if (dmaDone) begin
      dmaFlag_ff <= 1'b1; // [R3] [R21]
    end else if (flagClr[BIT_DMA]) begin
      dmaFlag_ff <= 1'b0; // [R3]
    end
  end

  // Abort sets the transmit flag too, without waiting for the request to drop
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      txFlag_ff <= 1'b0;
    end else if (txFall || evt.txAbort) begin
      txFlag_ff <= 1'b1; // [R5] [R11] [R21]
    end else if (flagClr[BIT_TX]) begin
      txFlag_ff <= 1'b0; // [R5]
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      txErrFlag_ff <= 1'b0;
    end else if (evt.txAbort) begin
      txErrFlag_ff <= 1'b1; // [R11] [R21]
    end else if (flagClr[BIT_TXERR]) begin
      txErrFlag_ff <= 1'b0; // [R11]
    end
  end

  assign rxCountFull = rxPacketDone && (pktCount_ff == PKT_COUNT_MAX);
  assign rxErrEvt = rxOverflow || rxBandwidthErr || rxCountFull; // [R6]

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      rxErrFlag_ff <= 1'b0;
    end else if (rxErrEvt) begin
      rxErrFlag_ff <= 1'b1; // [R6] [R7] [R21]
    end else if (flagClr[BIT_RXERR]) begin
      rxErrFlag_ff <= 1'b0; // [R7]
    end
  end

  // Errored packet is dropped for good, never counted
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      rxDiscard_ff <= 1'b0;
    end else begin
      rxDiscard_ff <= rxErrEvt; // [R7]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Packet count
  assign pktInc = rxPacketDone && !rxErrEvt;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      pktCount_ff <= RESET_BYTE;
    end else if (pktInc && !packet_decrement) begin
      pktCount_ff <= pktCount_ff + 8'h01;
    end else if (packet_decrement && !pktInc) begin
      pktCount_ff <= pktCount_ff - 8'h01; // [R2]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status bits and abort follow-up
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      bufErr_ff <= 1'b0;
    end else if (rxBandwidthErr || evt.txUnderrun) begin
      bufErr_ff <= 1'b1; // [R9] [R14]
    end else if (statusClr[BIT_BUFFER_ERROR]) begin
      bufErr_ff <= 1'b0; // [R13]
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      txAbortStat_ff <= 1'b0;
    end else if (evt.txAbort) begin
      txAbortStat_ff <= 1'b1; // [R12]
    end else if (statusClr[BIT_TX_ABORT]) begin
      txAbortStat_ff <= 1'b0; // [R13]
    end
  end

  // No retry: the request is dropped and only the status vector is written
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      txReqClr_ff <= 1'b0;
      txStatWr_ff <= 1'b0;
      txStatAddr_ff <= RESET_WORD;
    end else begin
      txReqClr_ff <= evt.txAbort; // [R12]
      txStatWr_ff <= evt.txAbort; // [R12]
      if (evt.txAbort) begin
        txStatAddr_ff <= txEndPointer + TX_STATUS_OFFSET; // [R12]
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt request
  always_comb begin
    flagVec = RESET_BYTE;
    flagVec[BIT_PKT] = (pktCount_ff != RESET_BYTE); // [R2]
    flagVec[BIT_DMA] = dmaFlag_ff;
    flagVec[BIT_LINK] = evt.linkFlag; // [R4]
    flagVec[BIT_TX] = txFlag_ff;
    flagVec[BIT_TXERR] = txErrFlag_ff;
    flagVec[BIT_RXERR] = rxErrFlag_ff;
  end

  always_comb begin
    statusVec = RESET_BYTE;
    statusVec[BIT_BUFFER_ERROR] = bufErr_ff;
    statusVec[BIT_TX_ABORT] = txAbortStat_ff;
  end

  // Link flag is already gated by both PHY enables
  assign qualified = flagVec & irqEnable_ff & {8{ethGlobalEn}}; // [R8] [R19]
  assign ethIrq = |qualified; // [R22] [R23]

  ////////////////////////////////////////////////////////////////////////////
  // Register reads, one cycle after the address
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      regRdData_ff <= RESET_BYTE;
    end else if (regAddr == IDX_IRQ_ENABLE) begin
      regRdData_ff <= irqEnable_ff; // [R1]
    end else if (regAddr == IDX_IRQ_FLAGS) begin
      regRdData_ff <= flagVec;
    end else if (regAddr == IDX_STATUS) begin
      regRdData_ff <= statusVec;
    end else if (regAddr == IDX_PKT_COUNT) begin
      regRdData_ff <= pktCount_ff;
    end else begin
      regRdData_ff <= RESET_BYTE;
    end
  end

  assign regRdData = regRdData_ff;
  assign rxDiscard = rxDiscard_ff;
  assign txRequestClr = txReqClr_ff;
  assign txStatusWrite = txStatWr_ff;
  assign txStatusAddr = txStatAddr_ff;
  assign bufferError = bufErr_ff;
  assign txAbortStatus = txAbortStat_ff;

  ////////////////////////////////////////////////////////////////////////////
  sequence s_abort_seen;
    evt.txAbort;
  endsequence

  sequence s_abort_effects;
    txFlag_ff && txErrFlag_ff && txAbortStat_ff && txRequestClr && txStatusWrite;
  endsequence

  property p_abort;
    @(posedge mclk) disable iff (!rst_n)
      s_abort_seen |=> s_abort_effects ##1 (!txRequestClr || $past(evt.txAbort));
  endproperty
  a_abort: assert property (p_abort) else $error("abort effects missing"); // [R11] [R12]

  property p_rx_error;
    @(posedge mclk) disable iff (!rst_n)
      rxErrEvt && !packet_decrement |=> rxErrFlag_ff && rxDiscard && $stable(pktCount_ff);
  endproperty
  a_rx_error: assert property (p_rx_error) else $error("receive error not handled"); // [R6] [R7]

  property p_tx_fall;
    @(posedge mclk) disable iff (!rst_n)
      txFall |=> txFlag_ff;
  endproperty
  a_tx_fall: assert property (p_tx_fall) else $error("transmit flag not set"); // [R5]

  property p_irq_gate;
    @(posedge mclk) disable iff (!rst_n)
      ethIrq |-> ethGlobalEn && ((irqEnable_ff & flagVec) != RESET_BYTE);
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("ungated interrupt"); // [R8]

  property p_buffer_error_cause;
    @(posedge mclk) disable iff (!rst_n)
      !bufErr_ff && !rxBandwidthErr && !evt.txUnderrun |=> !bufErr_ff;
  endproperty
  a_buffer_error_cause: assert property (p_buffer_error_cause) else $error("stray buffer error"); // [R9]

  property p_last_packet;
    @(posedge mclk) disable iff (!rst_n)
      (pktCount_ff == 8'h01) && packet_decrement && !rxPacketDone |=> !flagVec[BIT_PKT];
  endproperty
  a_last_packet: assert property (p_last_packet) else $error("pending flag stuck"); // [R2]

  property p_irq_drop;
    @(posedge mclk) disable iff (!rst_n)
      ethIrq && (regWrData == RESET_BYTE) && regWr && (regAddr == IDX_IRQ_ENABLE)
        |=> !ethIrq;
  endproperty
  a_irq_drop: assert property (p_irq_drop) else $error("interrupt held after disable"); // [R23]

  property p_link_irq;
    @(posedge mclk) disable iff (!rst_n)
      qualified[BIT_LINK] |-> evt.linkQualEn && irqEnable_ff[BIT_LINK] && ethGlobalEn;
  endproperty
  a_link_irq: assert property (p_link_irq) else $error("link interrupt not gated"); // [R19]

endmodule : eif_ethernet_interrupt_flags

// file: testbench/eif_host_model.sv
// Host-side model of the transmit request bit under firmware control
`timescale 1ns/10ps
module eif_host_model (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic hostSet,
  input wire logic hostCancel,
  input wire logic txRequestClr,
  output logic txRequest
);
  // Moves on the falling edge so the block samples a settled level
  always @(negedge mclk) begin
    if (!rst_n) begin
      txRequest <= 1'b0;
    end else if (txRequestClr) begin
      txRequest <= 1'b0;
    end else if (hostSet) begin
      txRequest <= 1'b1;
    end else if (hostCancel) begin
      txRequest <= 1'b0;
    end
  end
endmodule : eif_host_model

// file: testbench/tb_top.sv
// Self-checking bench for the Ethernet interrupt flag block
`timescale 1ns/10ps
module tb_top;
  import eif_pkg::*;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic [2:0] regAddr = 3'h0;
  logic regWr = 1'b0;
  logic [7:0] regWrData = 8'h00;
  logic ethGlobalEn = 1'b0;
  logic [8:0] evt = 9'h000;
  logic [4:0] lvl = 5'h00;
  logic [15:0] txEndPointer = 16'h0000;
  logic [15:0] txFrameLength = 16'h0000;
  logic [15:0] maxFrameLength = 16'h05ee;
  logic [10:0] txByteCount = 11'h000;
  logic [4:0] miiAddr = 5'h00;
  logic miiWr = 1'b0;
  logic miiRd = 1'b0;
  logic [15:0] miiWrData = 16'h0000;
  logic hostSet = 1'b0;
  logic hostCancel = 1'b0;
  logic txRequest, ethIrq, rxDiscard, txRequestClr, txStatusWrite, bufferError, txAbortStatus;
  logic [7:0] regRdData;
  logic [15:0] miiRdData, txStatusAddr;
  int err_count = 0;
  int cmp_count = 0;
  int cycles = 0;
  logic [31:0] seed = 32'h6779;
  logic [7:0] v;
  logic [15:0] ptr;

  eif_ethernet_interrupt_flags dut (.mclk, .rst_n, .regAddr, .regWr, .regWrData, .regRdData,
    .ethGlobalEn, .dmaDone(evt[0]), .txRequest, .txEndPointer, .rxPacketDone(evt[1]),
    .rxOverflow(evt[2]), .rxBandwidthErr(evt[3]), .miiAddr, .miiWr, .miiWrData, .miiRd,
    .miiRdData, .phyLinkEvent(evt[4]), .txStart(evt[8]), .txCollision(evt[6]), .txByteCount,
    .txDeferLimit(evt[7]), .deferEn(lvl[1]), .txFrameLength, .maxFrameLength,
    .hugeFrameEn(lvl[2]), .perPacketOverride(lvl[3]), .perPacketHugeEn(lvl[4]),
    .txUnderrunEvt(evt[5]), .fullDuplex(lvl[0]), .ethIrq, .rxDiscard, .txRequestClr,
    .txStatusWrite, .txStatusAddr, .bufferError, .txAbortStatus);
  eif_host_model host_i (.mclk, .rst_n, .hostSet, .hostCancel, .txRequestClr, .txRequest);

  ////////////////////////////////////////
  initial begin
    forever #2.5 mclk = ~mclk;
  end
  // Generous ceiling, the full run needs under 3000 cycles
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      test_done();
    end
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  function automatic logic irq_exp(input logic [7:0] f, input logic [7:0] e, input logic g);
    return g & |(f & e);
  endfunction : irq_exp
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic chk1(input logic seen, input logic exp);
    chk({15'h0000, seen}, {15'h0000, exp});
  endtask : chk1
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(negedge mclk);
    regAddr = a;
    regWr = 1'b1;
    regWrData = d;
    @(negedge mclk);
    regWr = 1'b0;
  endtask : wr
  // Read data is registered, so it is taken one cycle after the index
  task automatic rd(input logic [2:0] a, input logic [7:0] e);
    @(negedge mclk);
    regAddr = a;
    @(negedge mclk);
    chk({8'h00, regRdData}, {8'h00, e});
  endtask : rd
  task automatic mii(input logic w, input logic [4:0] a, input logic [15:0] d);
    @(negedge mclk);
    miiAddr = a;
    miiWr = w;
    miiRd = !w;
    miiWrData = d;
    @(negedge mclk);
    miiWr = 1'b0;
    miiRd = 1'b0;
  endtask : mii
  task automatic pulse(input int k);
    @(negedge mclk);
    evt[k] = 1'b1;
    @(negedge mclk);
    evt[k] = 1'b0;
  endtask : pulse
  task automatic host(input logic s);
    hostSet <= s;
    hostCancel <= !s;
    @(negedge mclk);
    hostSet <= 1'b0;
    hostCancel <= 1'b0;
    @(negedge mclk);
  endtask : host
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : test_done

  ////////////////////////////////////////
  initial begin
    repeat (4) @(posedge mclk);
    @(negedge mclk);
    rst_n = 1'b1;
    rd(IDX_IRQ_ENABLE, RESET_BYTE);
    rd(IDX_IRQ_FLAGS, RESET_BYTE);
    mii(1'b0, MII_IRQ_ENABLE, 16'h0000);
    chk(miiRdData, RESET_WORD);
    $display("test reset finished");
    for (int i = 0; i < 8; i++) begin
      seed = lfsr(seed);
      v = (i == 0) ? 8'hff : seed[7:0];
      ethGlobalEn = v[7];
      wr(IDX_IRQ_ENABLE, v);
      rd(IDX_IRQ_ENABLE, v & IRQ_ENABLE_MASK);
      pulse(0);
      rd(IDX_IRQ_FLAGS, 8'h20);
      chk1(ethIrq, irq_exp(8'h20, v & IRQ_ENABLE_MASK, v[7]));
      wr(IDX_IRQ_FLAGS, 8'hdf);
      chk1(ethIrq, 1'b0);
    end
    $display("test enables finished");
    wr(IDX_IRQ_ENABLE, 8'h10);
    ethGlobalEn = 1'b1;
    pulse(4);
    rd(IDX_IRQ_FLAGS, 8'h00);
    mii(1'b1, MII_IRQ_ENABLE, 16'hffff);
    mii(1'b0, MII_IRQ_ENABLE, 16'h0000);
    chk(miiRdData, PHY_ENABLE_MASK);
    pulse(4);
    rd(IDX_IRQ_FLAGS, 8'h10);
    chk1(ethIrq, 1'b1);
    wr(IDX_IRQ_FLAGS, 8'h00);
    rd(IDX_IRQ_FLAGS, 8'h10);
    mii(1'b0, MII_IRQ_FLAGS, 16'h0000);
    chk(miiRdData, 16'h0014);
    rd(IDX_IRQ_FLAGS, 8'h00);
    $display("test link finished");
    pulse(1);
    pulse(1);
    rd(IDX_PKT_COUNT, 8'h02);
    wr(IDX_CONTROL_TWO, 8'h40);
    rd(IDX_IRQ_FLAGS, 8'h40);
    wr(IDX_CONTROL_TWO, 8'h40);
    rd(IDX_IRQ_FLAGS, 8'h00);
    pulse(2);
    chk1(rxDiscard, 1'b1);
    rd(IDX_STATUS, 8'h00);
    pulse(3);
    rd(IDX_STATUS, 8'h40);
    rd(IDX_IRQ_FLAGS, 8'h01);
    wr(IDX_IRQ_FLAGS, 8'h00);
    wr(IDX_STATUS, 8'h00);
    for (int i = 0; i < 256; i++) pulse(1);
    rd(IDX_IRQ_FLAGS, 8'h41);
    rd(IDX_PKT_COUNT, PKT_COUNT_MAX);
    for (int i = 0; i < 255; i++) wr(IDX_CONTROL_TWO, 8'h40);
    wr(IDX_IRQ_FLAGS, 8'h00);
    rd(IDX_IRQ_FLAGS, 8'h00);
    $display("test receive finished");
    // Underrun, late collision, oversize abort; deferral and override do not
    for (int k = 0; k < 5; k++) begin
      seed = lfsr(seed);
      ptr = seed[15:0];
      txEndPointer = ptr;
      lvl = {k == 4, k == 4, 1'b0, k == 3, k == 0};
      txByteCount = 11'h041;
      txFrameLength = 16'h0640;
      host(1'b1);
      pulse(k == 0 ? 5 : k == 1 ? 6 : k == 3 ? 7 : 8);
      @(negedge mclk);
      chk1(txRequestClr, k < 3);
      if (k < 3) begin
        chk(txStatusAddr, ptr + TX_STATUS_OFFSET);
        chk1(txStatusWrite, 1'b1);
        chk1(bufferError, k == 0);
        chk1(txAbortStatus, 1'b1);
        rd(IDX_STATUS, k == 0 ? 8'h42 : 8'h02);
        rd(IDX_IRQ_FLAGS, 8'h0a);
        chk1(txRequest, 1'b0);
        wr(IDX_STATUS, 8'h00);
      end else begin
        chk1(txAbortStatus, 1'b0);
        host(1'b0);
        rd(IDX_IRQ_FLAGS, 8'h08);
      end
      wr(IDX_IRQ_FLAGS, 8'h00);
    end
    // Sixteenth collision and deferral abort; full duplex ignores collisions
    lvl = 5'h00;
    txByteCount = 11'h010;
    txFrameLength = 16'h0040;
    host(1'b1);
    pulse(8);
    for (int i = 0; i < 15; i++) pulse(6);
    rd(IDX_IRQ_FLAGS, 8'h00);
    pulse(6);
    rd(IDX_STATUS, 8'h02);
    wr(IDX_STATUS, 8'h00);
    host(1'b1);
    pulse(7);
    rd(IDX_STATUS, 8'h02);
    wr(IDX_STATUS, 8'h00);
    lvl = 5'h01;
    txByteCount = 11'h041;
    host(1'b1);
    pulse(6);
    rd(IDX_STATUS, 8'h00);
    $display("test transmit finished");
    test_done();
  end
endmodule : tb_top
